// file: hw/flash_pkg.sv
// Constants shared by the serial flash command front end
package flash_pkg;
    // Opcodes
    localparam logic [7:0] OP_QUAD_READ   = 8'hEB;
    localparam logic [7:0] OP_PAGE_PROG   = 8'h02;
    localparam logic [7:0] OP_QUAD_PROG_A = 8'h32;
    localparam logic [7:0] OP_QUAD_PROG_B = 8'h38;
    localparam logic [7:0] OP_WRITE_EN    = 8'h06;
    localparam logic [7:0] OP_ENTER_FOUR  = 8'h35;
    localparam logic [7:0] OP_EXIT_FOUR   = 8'hF5;
    localparam logic [7:0] OP_STATUS_RD   = 8'h05;
    localparam logic [3:0] MODE_KEEP_NIB  = 4'hA;

    // Last beat index per phase (beats minus one); MODE_BEATS is a beat count
    localparam logic [4:0] BEATS_BYTE_1   = 5'h07;
    localparam logic [4:0] BEATS_BYTE_4   = 5'h01;
    localparam logic [4:0] BEATS_ADDR_1   = 5'h17;
    localparam logic [4:0] BEATS_ADDR_4   = 5'h05;
    localparam logic [3:0] MODE_BEATS     = 4'h2;

    // Register port map
    localparam int         REG_AW         = 4;
    localparam logic [3:0] OFS_CONFIG     = 4'h0;
    localparam logic [3:0] OFS_DUMMY      = 4'h4;
    localparam logic [3:0] OFS_STATUS     = 4'h8;
    localparam logic [3:0] DUMMY_RESET    = 4'h6;
    localparam int         CFG_QE_BIT     = 0;
    localparam int         CFG_BP_LSB     = 1;
    localparam int         BP_W           = 4;

    // Status byte layout
    localparam int         ST_WIP_BIT     = 0;
    localparam int         ST_WEL_BIT     = 1;
    localparam int         ST_FOUR_BIT    = 2;
    localparam int         ST_CONT_BIT    = 3;

    // Timing
    localparam int         CLK_PERIOD_NS  = 100;
    localparam int         PROG_TIME_NS   = 3000;
    localparam int         PROG_CYCLES    = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0000,
        ST_CMD   = 4'b0001,
        ST_ADDR  = 4'b0010,
        ST_MODE  = 4'b0011,
        ST_DUMMY = 4'b0100,
        ST_RDATA = 4'b0101,
        ST_PDATA = 4'b0110,
        ST_STAT  = 4'b0111,
        ST_DONE  = 4'b1000,
        ST_SKIP  = 4'b1001
    } link_state_t;

    typedef enum logic [1:0] {
        PG_IDLE  = 2'b00,
        PG_WRITE = 2'b01,
        PG_WAIT  = 2'b10
    } prog_state_t;
endpackage

// file: hw/flash_front_end.sv
// Serial flash front end: quad I/O read, page program, four-line mode
// Function
// [RULE1] Host sets quad_io_enable before quad read in single-line mode; the code accepts EBh without quad_io_enable.
// [RULE2] Quad read EBh, 24-bit nibble address, configurable dummy default 6.
// [RULE3] Address nibbles arrive MSB first, highest bit on IO3.
// [RULE4] Read data driven on falling edge, nibble MSB on IO3.
// [RULE5] Read address increments per byte, wraps to zero past top.
// [RULE6] Read runs while chip select low; high stops data drive.
// [RULE7] First two dummy clocks carry the mode byte as nibbles.
// [RULE8] Mode upper nibble Ah enters continuous read; next read skips opcode.
// [RULE9] Mode lower nibble ignored; other upper nibble leaves continuous read.
// [RULE10] Dummy count includes the two mode clocks.
// [RULE11] Reads leave the command line mode unchanged.
// [RULE12] Quad read ignored while a write is in progress.
// [RULE13] Four-line mode takes opcode in two clocks, no enable needed.
// [RULE14] Page program 02h: opcode, address, 1 to 256 bytes.
// [RULE15] Page program into a protected page is ignored.
// [RULE16] Page program runs only with write_enable_latch set.
// [RULE17] Program starts at chip select rise; bad termination cancels.
// [RULE18] write_in_progress is 1 during program, 0 after, status readable.
// [RULE19] Data past page end wraps in page; last 256 bytes kept.
// [RULE20] Page bytes not loaded stay unchanged.
// [RULE21] Programming only clears bits.
// [RULE22] Quad program 32h/38h needs quad_io_enable and the latch; in four-line mode it is accepted without quad_io_enable.
// [RULE23] 35h enters, F5h leaves four-line command mode.
// [RULE24] 06h sets write_enable_latch.
// [RULE25] write_enable_latch clears when a program completes.
// [RULE26] Quad program address and data use read nibble order.
`timescale 1ns/10ps
module flash_front_end #(
    parameter int ARRAY_AW   = 12,
    parameter int PROG_WAIT  = flash_pkg::PROG_CYCLES
) (
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    input  wire logic                        sck,
    input  wire logic                        cs_n,
    input  wire logic [3:0]                  io_in,
    output logic      [3:0]                  io_out,
    output logic      [3:0]                  io_oe,
    input  wire logic [flash_pkg::REG_AW-1:0] reg_addr,
    input  wire logic [7:0]                  reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [7:0]                  reg_rdata
);
    import flash_pkg::*;

    localparam int ARRAY_BYTES = 1 << ARRAY_AW;

    logic [2:0]  sck_s;
    logic [2:0]  cs_s;
    logic [3:0]  io_m;
    logic [3:0]  io_s;
    link_state_t state;
    prog_state_t pg_state;
    logic [4:0]  cnt;
    logic [23:0] sh;
    logic [7:0]  op;
    logic [23:0] addr;
    logic [2:0]  beat;
    logic        cont;
    logic        write_in_progress;
    logic        write_enable_latch;
    logic        four_line;
    logic        qe;
    logic [BP_W-1:0] bp;
    logic [3:0]  dummy_cfg;
    logic [7:0]  mem [ARRAY_BYTES];
    logic [7:0]  pbuf [256];
    logic [255:0] loaded;
    logic [7:0]  pcol;
    logic        pgot;
    logic [7:0]  pidx;
    logic [15:0] pwait;
    logic [23:0] paddr;

    // Edge finding looks only at the second and third stages
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sck_s <= 3'h0;
            cs_s  <= 3'h7;
            io_m  <= 4'h0;
            io_s  <= 4'h0;
        end
        else
        begin
            sck_s <= {sck_s[1:0], sck};
            cs_s  <= {cs_s[1:0], cs_n};
            io_m  <= io_in;
            io_s  <= io_m;
        end
    end

    logic sck_rise;
    logic sck_fall;
    logic sel;
    logic cs_rise;
    logic cs_fall;
    logic wide;
    logic is_prog;
    logic [4:0] last_beat;
    logic [23:0] next_sh;
    logic [3:0] dummy_eff;
    logic [7:0] status_byte;
    logic [7:0] rd_byte;
    logic [ARRAY_AW-1:0] next_raddr;
    logic prot;

    assign sck_rise = sck_s[1] & ~sck_s[2];
    assign sck_fall = ~sck_s[1] & sck_s[2];
    assign sel      = ~cs_s[1];
    assign cs_rise  = cs_s[1] & ~cs_s[2];
    assign cs_fall  = ~cs_s[1] & cs_s[2];
    assign is_prog  = (op == OP_PAGE_PROG) | (op == OP_QUAD_PROG_A) | (op == OP_QUAD_PROG_B);
    // Four lines after the opcode for reads and quad program
    assign wide = four_line | ((state != ST_CMD) & (op != OP_PAGE_PROG)); // see [RULE13] [RULE26]
    assign next_sh = wide ? {sh[19:0], io_s} : {sh[22:0], io_s[0]}; // see [RULE3] [RULE2]
    assign dummy_eff = (dummy_cfg < MODE_BEATS) ? MODE_BEATS : dummy_cfg;
    assign status_byte = {4'h0, cont, four_line, write_enable_latch, write_in_progress}; // see [RULE18]
    assign rd_byte = mem[addr[ARRAY_AW-1:0]];
    assign next_raddr = addr[ARRAY_AW-1:0] + 1'b1; // see [RULE5]
    // Top bp sixteenths of the array are protected
    assign prot = (bp != '0) &&
        ({1'b0, addr[ARRAY_AW-1 -: 4]} >= (5'h10 - {1'b0, bp})); // see [RULE15]

    always_comb
    begin
        last_beat = wide ? BEATS_BYTE_4 : BEATS_BYTE_1;
        if (state == ST_ADDR)
        begin
            last_beat = wide ? BEATS_ADDR_4 : BEATS_ADDR_1;
        end
        else if (state == ST_MODE)
        begin
            last_beat = {1'b0, MODE_BEATS} - 5'h01;
        end
        else if (state == ST_DUMMY)
        begin
            last_beat = {1'b0, dummy_eff} - {1'b0, MODE_BEATS} - 5'h01; // see [RULE10]
        end
    end

    logic beat_end;
    assign beat_end = sck_rise & sel & (cnt == last_beat);

    // Link sequencer
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= ST_IDLE;
            cnt   <= 5'h00;
            sh    <= 24'h000000;
            op    <= 8'h00;
            addr  <= 24'h000000;
            beat  <= 3'h0;
            cont  <= 1'b0;
        end
        else if (!sel)
        begin
            state <= ST_IDLE; // see [RULE6]
        end
        else if (cs_fall)
        begin
            cnt  <= 5'h00;
            beat <= 3'h0;
            if (cont)
            begin
                op    <= OP_QUAD_READ;
                state <= write_in_progress ? ST_SKIP : ST_ADDR; // see [RULE8] [RULE12]
            end
            else
            begin
                state <= ST_CMD;
            end
        end
        else if (sck_rise)
        begin
            sh  <= next_sh;
            cnt <= cnt + 5'h01;
            case (state)
                ST_CMD:
                    if (beat_end)
                    begin
                        cnt <= 5'h00;
                        op  <= next_sh[7:0];
                        if (write_in_progress && next_sh[7:0] != OP_STATUS_RD)
                            state <= ST_SKIP; // see [RULE12]
                        else if (next_sh[7:0] == OP_QUAD_READ ||
                                 next_sh[7:0] == OP_PAGE_PROG)
                            state <= ST_ADDR; // see [RULE2] [RULE14]
                        else if (next_sh[7:0] == OP_QUAD_PROG_A ||
                                 next_sh[7:0] == OP_QUAD_PROG_B)
                            state <= (qe | four_line) ? ST_ADDR : ST_SKIP; // see [RULE22]
                        else if (next_sh[7:0] == OP_STATUS_RD)
                            state <= ST_STAT;
                        else if (next_sh[7:0] == OP_WRITE_EN ||
                                 next_sh[7:0] == OP_ENTER_FOUR ||
                                 next_sh[7:0] == OP_EXIT_FOUR)
                            state <= ST_DONE;
                        else
                            state <= ST_SKIP;
                    end
                ST_ADDR:
                    if (beat_end)
                    begin
                        cnt   <= 5'h00;
                        addr  <= next_sh;
                        state <= is_prog ? ST_PDATA : ST_MODE;
                    end
                ST_MODE:
                    if (beat_end)
                    begin
                        cnt   <= 5'h00;
                        // Lower nibble is don't care
                        cont  <= (next_sh[7:4] == MODE_KEEP_NIB); // see [RULE7] [RULE8] [RULE9]
                        state <= (dummy_eff == MODE_BEATS) ? ST_RDATA : ST_DUMMY;
                    end
                ST_DUMMY:
                    if (beat_end)
                    begin
                        cnt   <= 5'h00;
                        state <= ST_RDATA; // see [RULE10]
                    end
                ST_PDATA:
                    if (beat_end)
                    begin
                        cnt <= 5'h00;
                    end
                ST_DONE:
                    state <= ST_SKIP; // see [RULE17]
                default:
                    cnt <= 5'h00;
            endcase
        end
        else if (sck_fall && state == ST_RDATA)
        begin
            beat <= beat + 3'h1;
            if (beat[0])
            begin
                addr <= {{(24 - ARRAY_AW){1'b0}}, next_raddr}; // see [RULE5]
            end
        end
        else if (sck_fall && state == ST_STAT)
        begin
            beat <= beat + (four_line ? 3'h4 : 3'h1);
        end
    end

    // Pins driven only on falling link edges, released with chip select
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            io_out <= 4'h0;
            io_oe  <= 4'h0;
        end
        else if (!sel)
        begin
            io_oe <= 4'h0; // see [RULE6]
        end
        else if (sck_fall && state == ST_RDATA)
        begin
            io_out <= beat[0] ? rd_byte[3:0] : rd_byte[7:4]; // see [RULE4]
            io_oe  <= 4'hF;
        end
        else if (sck_fall && state == ST_STAT)
        begin
            if (four_line)
            begin
                io_out <= beat[2] ? status_byte[3:0] : status_byte[7:4];
                io_oe  <= 4'hF;
            end
            else
            begin
                io_out <= {2'b00, status_byte[3'h7 - beat], 1'b0};
                io_oe  <= 4'h2;
            end
        end
    end

    // Page buffer; column wraps inside the page
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            loaded <= '0;
            pcol   <= 8'h00;
            pgot   <= 1'b0;
            for (int i = 0; i < 256; i++)
                pbuf[i] <= 8'hFF;
        end
        else if (beat_end && state == ST_ADDR && is_prog)
        begin
            loaded <= '0;
            pgot   <= 1'b0;
            pcol   <= next_sh[7:0]; // see [RULE20]
        end
        else if (beat_end && state == ST_PDATA)
        begin
            pbuf[pcol]   <= next_sh[7:0];
            loaded[pcol] <= 1'b1;
            pgot         <= 1'b1;
            pcol         <= pcol + 8'h01; // see [RULE19]
        end
    end

    logic prog_go;
    logic prog_end;
    // Whole byte received and no stray clocks
    assign prog_go = cs_rise && state == ST_PDATA && cnt == 5'h00 && pgot && write_enable_latch && !prot
        && !write_in_progress; // see [RULE16] [RULE17] [RULE15]
    assign prog_end = (pg_state == PG_WAIT) && (pwait == 16'h0000);

    // Program engine: one byte per clock, then the cell time
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pg_state <= PG_IDLE;
            pidx     <= 8'h00;
            pwait    <= 16'h0000;
            paddr    <= 24'h000000;
            for (int i = 0; i < ARRAY_BYTES; i++)
                mem[i] <= 8'hFF;
        end
        else
        begin
            case (pg_state)
                PG_IDLE:
                    if (prog_go)
                    begin
                        pg_state <= PG_WRITE;
                        pidx     <= 8'h00;
                        paddr    <= addr;
                    end
                PG_WRITE:
                begin
                    if (loaded[pidx])
                    begin
                        // AND keeps erased-to-programmed direction only
                        mem[{paddr[ARRAY_AW-1:8], pidx}] <=
                            mem[{paddr[ARRAY_AW-1:8], pidx}] & pbuf[pidx]; // see [RULE21] [RULE20]
                    end
                    pidx <= pidx + 8'h01;
                    if (pidx == 8'hFF)
                    begin
                        pg_state <= PG_WAIT;
                        pwait    <= PROG_WAIT[15:0];
                    end
                end
                PG_WAIT:
                    if (pwait == 16'h0000)
                        pg_state <= PG_IDLE;
                    else
                        pwait <= pwait - 16'h0001;
                default:
                    pg_state <= PG_IDLE;
            endcase
        end
    end

    // Device flags, set at the closing chip select edge; busy and latch clear when a program ends
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            write_in_progress       <= 1'b0;
            write_enable_latch       <= 1'b0;
            four_line <= 1'b0;
        end
        else if (prog_end)
        begin
            write_in_progress <= 1'b0; // see [RULE18]
            write_enable_latch <= 1'b0; // see [RULE25]
        end
        else if (prog_go)
        begin
            write_in_progress <= 1'b1; // see [RULE18] [RULE17]
        end
        else if (cs_rise && state == ST_DONE)
        begin
            if (op == OP_WRITE_EN)
                write_enable_latch <= 1'b1; // see [RULE24]
            else if (op == OP_ENTER_FOUR)
                four_line <= 1'b1; // see [RULE23]
            else if (op == OP_EXIT_FOUR && four_line)
                four_line <= 1'b0; // see [RULE23] [RULE11]
        end
    end

    // Register port
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            qe        <= 1'b0;
            bp        <= '0;
            dummy_cfg <= DUMMY_RESET;
        end
        else if (reg_wr && reg_addr == OFS_CONFIG)
        begin
            qe <= reg_wdata[CFG_QE_BIT];
            bp <= reg_wdata[CFG_BP_LSB +: BP_W];
        end
        else if (reg_wr && reg_addr == OFS_DUMMY)
        begin
            dummy_cfg <= reg_wdata[3:0]; // see [RULE2]
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= 8'h00;
        else if (reg_rd && reg_addr == OFS_CONFIG)
            reg_rdata <= {3'h0, bp, qe};
        else if (reg_rd && reg_addr == OFS_DUMMY)
            reg_rdata <= {4'h0, dummy_cfg};
        else if (reg_rd && reg_addr == OFS_STATUS)
            reg_rdata <= status_byte; // see [RULE18]
        else
            reg_rdata <= 8'h00;
    end
endmodule // flash_front_end

// file: tb/flash_front_end_checker.sv
// Port-level assertions for the flash front end
`timescale 1ns/10ps
module flash_front_end_checker
    import flash_pkg::*;
#(
    parameter int ARRAY_AW  = 12,
    parameter int PROG_WAIT = 2
) (
    input wire logic                        clk,
    input wire logic                        rst_n,
    input wire logic                        sck,
    input wire logic                        cs_n,
    input wire logic [3:0]                  io_in,
    input wire logic [3:0]                  io_out,
    input wire logic [3:0]                  io_oe,
    input wire logic [flash_pkg::REG_AW-1:0] reg_addr,
    input wire logic [7:0]                  reg_wdata,
    input wire logic                        reg_wr,
    input wire logic                        reg_rd,
    input wire logic [7:0]                  reg_rdata
);
    logic [3:0] since_fall;

    // Saturates so a long idle link never wraps into a false match
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            since_fall <= 4'hF;
        else if ($fell(sck))
            since_fall <= 4'h0;
        else if (since_fall != 4'hF)
            since_fall <= since_fall + 4'h1;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not idle");
    a_unmapped_zero: assert property (reg_rd && reg_addr == 4'hC |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_status_top: assert property (
        reg_rd && reg_addr == OFS_STATUS |=> reg_rdata[7:4] == 4'h0)
        else $error("status upper bits set");
    a_cfg_back: assert property (
        reg_wr && reg_addr == OFS_CONFIG ##1 reg_rd && reg_addr == OFS_CONFIG
        |=> reg_rdata == ($past(reg_wdata, 2) & 8'h1F))
        else $error("config readback wrong");
    a_dummy_back: assert property (
        $past(reg_wr && reg_addr == OFS_DUMMY) && reg_rd
        && reg_addr == OFS_DUMMY && $past(reg_wdata[3:0]) >= 4'h2
        |=> reg_rdata == {4'h0, $past(reg_wdata[3:0], 2)})
        else $error("dummy readback wrong");
    a_oe_release: assert property (cs_n [*6] |-> io_oe == 4'h0)
        else $error("drive kept after deselect");
    a_oe_selected: assert property ($rose(|io_oe) |-> !cs_n)
        else $error("drive began while deselected");
    a_oe_shape: assert property (io_oe == 4'h0 || io_oe == 4'h2 || io_oe == 4'hF)
        else $error("odd drive enable");
    a_out_on_fall: assert property ($changed(io_out) && !cs_n |-> since_fall <= 4'h6)
        else $error("output moved away from a falling edge");

    c_quad_out: cover property (io_oe == 4'hF);
    c_busy_seen: cover property (reg_rd && reg_addr == OFS_STATUS ##1 reg_rdata[ST_WIP_BIT]);
    c_frame_end: cover property ($rose(cs_n));
endmodule // flash_front_end_checker

// file: tb/flash_host_model.sv
// Serial host controller model for the flash link
`timescale 1ns/10ps
module flash_host_model (
    input  wire logic       clk,
    input  wire logic [3:0] io_out,
    output logic            sck,
    output logic            cs_n,
    output logic      [3:0] io_in
);
    initial
    begin
        sck = 1'b0;
        cs_n = 1'b1;
        io_in = 4'h0;
    end

    // Released lines toggle, since nothing pulls them
    task automatic beat(input logic [3:0] v, input logic drv, output logic [3:0] r);
        io_in <= drv ? v : ~io_in;
        repeat (4) @(posedge clk);
        sck <= 1'b1;
        repeat (4) @(posedge clk);
        r = io_out;
        sck <= 1'b0;
    endtask

    task automatic send_byte(input logic [7:0] b, input logic four);
        logic [3:0] r;
        for (int i = 0; i < (four ? 2 : 8); i++)
            beat(four ? b[7-4*i -: 4] : {~io_in[3:1], b[7-i]}, 1'b1, r);
    endtask

    task automatic start();
        cs_n <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    // Clock stays low while deselected
    task automatic stop();
        repeat (4) @(posedge clk);
        cs_n <= 1'b1;
        repeat (6) @(posedge clk);
    endtask
endmodule // flash_host_model

// file: tb/tb_flash_front_end.sv
// Self-checking bench for the flash front end
`timescale 1ns/10ps
module tb_flash_front_end;
    import flash_pkg::*;
    logic              clk, rst_n, sck, cs_n, reg_wr, reg_rd, four, cont;
    logic [3:0]        io_in, io_out, io_oe;
    logic [REG_AW-1:0] reg_addr;
    logic [7:0]        reg_wdata, reg_rdata, rd;
    logic [7:0]        mem [0:4095];
    logic [7:0]        pd [$];
    int                errors, comparisons, dum;

    flash_front_end #(.ARRAY_AW(12), .PROG_WAIT(2)) i_dut (.clk(clk), .rst_n(rst_n),
        .sck(sck), .cs_n(cs_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));
    flash_host_model i_host (.clk(clk), .io_out(io_out), .sck(sck), .cs_n(cs_n), .io_in(io_in));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_get(input logic [3:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        rd = reg_rdata;
    endtask

    task automatic rd_chk(input string what, input logic [3:0] a, input logic [7:0] exp);
        reg_get(a);
        check(what, rd, exp);
    endtask

    task automatic cmd(input logic [7:0] op);
        i_host.start();
        i_host.send_byte(op, four);
        i_host.stop();
    endtask

    // Wide phases are nibbles, except plain program in single-line mode
    task automatic prog(input logic [7:0] op, input logic [23:0] a, input int tail,
                        input logic ok);
        logic [3:0] r;
        logic       wide;
        wide = four || op != OP_PAGE_PROG;
        i_host.start();
        i_host.send_byte(op, four);
        for (int k = 0; k < 3; k++)
            i_host.send_byte(a[23-8*k -: 8], wide);
        foreach (pd[j])
            i_host.send_byte(pd[j], wide);
        repeat (tail) i_host.beat(4'h0, 1'b1, r);
        i_host.stop();
        reg_get(OFS_STATUS);
        check("busy after frame", rd & 8'h01, {7'h00, ok});
        if (ok)
            foreach (pd[j])
                mem[{a[11:8], a[7:0] + 8'(j)}] &= pd[j];
    endtask

    task automatic wait_done();
        for (int i = 0; i < 300; i++)
        begin
            reg_get(OFS_STATUS);
            if (rd[ST_WIP_BIT] === 1'b0)
                break;
        end
        check("status after program", rd, {4'h0, cont, four, 2'b00});
    endtask

    // Status over the link: bits on IO1, or nibbles in four-line mode
    task automatic sread(input logic [7:0] exp);
        logic [3:0] r;
        logic [7:0] s;
        i_host.start();
        i_host.send_byte(OP_STATUS_RD, four);
        repeat (four ? 2 : 8)
        begin
            i_host.beat(4'h0, 1'b0, r);
            s = four ? {s[3:0], r} : {s[6:0], r[1]};
        end
        check("status drive", {4'h0, io_oe}, four ? 8'h0F : 8'h02);
        i_host.stop();
        check("link status", s, exp);
    endtask

    task automatic qread(input logic op, input logic [23:0] a, input logic [7:0] m, input int n,
                         input logic busy);
        logic [3:0] hi, lo;
        i_host.start();
        if (op)
            i_host.send_byte(OP_QUAD_READ, four);
        for (int k = 0; k < 3; k++)
            i_host.send_byte(a[23-8*k -: 8], 1'b1);
        i_host.send_byte(m, 1'b1);
        repeat (dum - 2) i_host.beat(4'h0, 1'b0, hi);
        for (int j = 0; j < n; j++)
        begin
            i_host.beat(4'h0, 1'b0, hi);
            i_host.beat(4'h0, 1'b0, lo);
            if (busy)
                check("drive while busy", {4'h0, io_oe}, 8'h00);
            else
                check("read byte", {hi, lo}, mem[12'(a + j)]);
        end
        i_host.stop();
        if (!busy)
            cont = (m[7:4] == MODE_KEEP_NIB);
    endtask

    initial
    begin
        #2000000;
        errors++;
        $display("watchdog expired");
        complete_run();
    end

    initial
    begin
        rst_n = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        four = 1'b0;
        cont = 1'b0;
        dum = 4;
        errors = 0;
        comparisons = 0;
        foreach (mem[i])
            mem[i] = 8'hFF;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rd_chk("config", OFS_CONFIG, 8'h00);
        rd_chk("dummy", OFS_DUMMY, 8'h06);
        wr(OFS_STATUS, 8'hFF);
        rd_chk("status", OFS_STATUS, 8'h00);
        rd_chk("unmapped", 4'hC, 8'h00);
        wr(OFS_DUMMY, 8'h04);
        rd_chk("dummy", OFS_DUMMY, 8'h04);
        $display("test registers done");
        cmd(OP_WRITE_EN);
        rd_chk("latch", OFS_STATUS, 8'h02);
        pd = '{8'hA5, 8'h3C, 8'h0F};
        prog(OP_PAGE_PROG, 24'h0000FE, 0, 1'b1);
        wait_done();
        $display("test page program done");
        wr(OFS_CONFIG, 8'h01);
        rd_chk("config", OFS_CONFIG, 8'h01);
        qread(1'b1, 24'h0000FC, 8'hA5, 6, 1'b0);
        wr(OFS_DUMMY, 8'h06);
        dum = 6;
        rd_chk("continuous", OFS_STATUS, 8'h08);
        qread(1'b0, 24'hFFFFFE, 8'h00, 4, 1'b0);
        qread(1'b1, 24'h000100, 8'hF0, 1, 1'b0);
        rd_chk("continuous off", OFS_STATUS, 8'h00);
        $display("test quad read done");
        pd = '{8'h00};
        prog(OP_PAGE_PROG, 24'h000200, 0, 1'b0);
        wr(OFS_CONFIG, 8'h03);
        cmd(OP_WRITE_EN);
        prog(OP_QUAD_PROG_A, 24'h000F10, 0, 1'b0);
        prog(OP_PAGE_PROG, 24'h000200, 3, 1'b0);
        $display("test refused programs done");
        cmd(OP_WRITE_EN);
        pd = '{8'hF0, 8'h55};
        prog(OP_QUAD_PROG_B, 24'h0000FF, 0, 1'b1);
        sread(8'h03);
        qread(1'b1, 24'h000000, 8'h00, 1, 1'b1);
        wait_done();
        $display("test quad program done");
        cmd(OP_ENTER_FOUR);
        four = 1'b1;
        rd_chk("four line", OFS_STATUS, 8'h04);
        sread(8'h04);
        qread(1'b1, 24'h0000FE, 8'hA0, 3, 1'b0);
        rd_chk("four and continuous", OFS_STATUS, 8'h0C);
        qread(1'b0, 24'h000000, 8'h10, 1, 1'b0);
        cmd(OP_EXIT_FOUR);
        four = 1'b0;
        rd_chk("single line", OFS_STATUS, 8'h00);
        $display("test four line mode done");
        complete_run();
    end
endmodule // tb_flash_front_end

bind flash_front_end flash_front_end_checker #(.ARRAY_AW(ARRAY_AW), .PROG_WAIT(PROG_WAIT)) i_chk (
    .clk(clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .io_in(io_in), .io_out(io_out),
    .io_oe(io_oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
